// ==== src/trh_map.svh ====
// offsets, field positions and reset values of the request header block
`ifndef TRH_MAP_SVH
`define TRH_MAP_SVH
// ***************************************
// register offsets
// ***************************************
`define TRH_OFF_CTRL      8'h90
`define TRH_OFF_PAGES     8'hE4
`define TRH_OFF_HDR0      8'hE8
`define TRH_OFF_HDR1      8'hEC
`define TRH_OFF_HDR2      8'hF0
`define TRH_OFF_HDR3      8'hF4
// ***************************************
// field positions, lsb in the register word
// ***************************************
`define TRH_VIEW_LSB      0
`define TRH_PKTZ_BIT      2
`define TRH_TX_LSB        16
`define TRH_RX_LSB        0
`define TRH_SPEED_LSB     16
`define TRH_LABEL_LSB     10
`define TRH_RETRY_LSB     8
`define TRH_TCODE_LSB     4
`define TRH_PRIO_LSB      0
`define TRH_ST_STAT_LSB   28
`define TRH_ST_RESPONSE_CODE_SEEN_LSB   24
`define TRH_ST_AERR_BIT   20
`define TRH_ST_ACK_LSB    16
`define TRH_ST_PST_LSB    12
`define TRH_ST_PRSP_LSB   8
`define TRH_ST_PAERR_BIT  4
// ***************************************
// codes and reset values
// ***************************************
`define TRH_VIEW_REQ      2'h0
`define TRH_VIEW_STAT     2'h1
`define TRH_TCODE_PKTZ    4'h1
`define TRH_WORD_RST      32'h0000_0000
`define TRH_CNT_RST       16'h0000
`define TRH_HDR0_RST      32'h0001_0010
`define TRH_HDR3_RST      32'h0008_0000
`define TRH_SPEED_RST     2'h1
`define TRH_TCODE_RST     4'h1
`endif

// ==== src/trh_pkg.sv ====
// types shared by the request header block modules
package trh_pkg;
  typedef logic [31:0] trh_word_t;
  typedef logic [3:0][31:0] trh_quads_t;
  // what the packetizer reports after a transaction
  typedef struct packed {
    logic [3:0]  stat;
    logic [3:0]  response_code_seen;
    logic        ack_fault;
    logic [3:0]  ack;
    logic [3:0]  page_fetch_state;
    logic [3:0]  page_fetch_response;
    logic        page_fetch_ack_fault;
    logic [31:0] page_number;
    logic [15:0] page_length;
    logic [15:0] table_hi;
    logic [31:0] table_lo;
  } trh_pkt_status_t;
endpackage

// ==== src/trh_cnt_if.sv ====
// link between the register block and one page entry counter
`timescale 1ns/1ps
interface trh_cnt_if;
  logic        load;
  logic [15:0] load_value;
  logic        sw_write;
  logic [15:0] sw_value;
  logic        fetch_done;
  logic [15:0] count;
  modport owner (output load, load_value, sw_write, sw_value, fetch_done, input count);
  modport counter (input load, load_value, sw_write, sw_value, fetch_done, output count);
endinterface

// ==== src/trh_page_counter.sv ====
// page table entry counter for one fifo direction
`timescale 1ns/1ps
`include "trh_map.svh"
module trh_page_counter
  import trh_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  reset_in,
  trh_cnt_if.counter cif
);
  logic [15:0] count;

  // orb load beats software write, which beats the decrement
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count <= `TRH_CNT_RST;
    end else if (cif.load) begin
      count <= cif.load_value;
    end else if (cif.sw_write) begin
      count <= cif.sw_value;
    end else if (cif.fetch_done && (count != `TRH_CNT_RST)) begin
      count <= count - 16'h0001;
    end
  end
  assign cif.count = count;

  fetch_dec_a: assert property (
    @(posedge clk_in) disable iff (reset_in)
    (cif.fetch_done && !cif.load && !cif.sw_write && count != 16'h0000)
      |=> (count == $past(count) - 16'h0001))
    else $error("page count did not step down by one");
  orb_load_a: assert property (
    @(posedge clk_in) disable iff (reset_in)
    cif.load |=> (count == $past(cif.load_value)))
    else $error("page count not loaded from orb size");
endmodule

// ==== src/trh_status_view.sv ====
// packetizer status quadlets captured on each status report
`timescale 1ns/1ps
`include "trh_map.svh"
module trh_status_view
  import trh_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            reset_in,
  input  wire logic            load_in,
  input  wire trh_pkt_status_t status_in,
  output trh_quads_t           quads_out
);
  trh_quads_t next_quads;

  // quadlet order: status, page number, length and table hi, table lo
  always_comb begin
    next_quads = '0;
    next_quads[0][`TRH_ST_STAT_LSB +: 4] = status_in.stat;
    next_quads[0][`TRH_ST_RESPONSE_CODE_SEEN_LSB +: 4] = status_in.response_code_seen;
    next_quads[0][`TRH_ST_AERR_BIT] = status_in.ack_fault;
    next_quads[0][`TRH_ST_ACK_LSB +: 4] = status_in.ack;
    next_quads[0][`TRH_ST_PST_LSB +: 4] = status_in.page_fetch_state;
    next_quads[0][`TRH_ST_PRSP_LSB +: 4] = status_in.page_fetch_response;
    next_quads[0][`TRH_ST_PAERR_BIT] = status_in.page_fetch_ack_fault;
    next_quads[1] = status_in.page_number;
    next_quads[2] = {status_in.page_length, status_in.table_hi};
    next_quads[3] = status_in.table_lo;
  end

  // holds until the next report; cleared only by reset
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      quads_out <= '0;
    end else if (load_in) begin
      quads_out <= next_quads;
    end
  end

  status_load_a: assert property (
    @(posedge clk_in) disable iff (reset_in)
    load_in |=> (quads_out[3] == $past(status_in.table_lo))
      && (quads_out[1] == $past(status_in.page_number)))
    else $error("status view not captured");
endmodule

// ==== src/trh_top.sv ====
// transmit request header and page count registers behind an apb slave
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "trh_map.svh"
module trh_top
  import trh_pkg::*;
(
  input  wire logic            CLK_IN,
  input  wire logic            RESET_IN,
  // apb slave
  input  wire logic            PSEL_IN,
  input  wire logic            PENABLE_IN,
  input  wire logic            PWRITE_IN,
  input  wire logic [7:0]      PADDR_IN,
  input  wire logic [31:0]     PWDATA_IN,
  input  wire logic [3:0]      PSTRB_IN,
  output logic [31:0]          PRDATA_OUT,
  output logic                 PREADY_OUT,
  output logic                 PSLVERR_OUT,
  // page table fetch engine
  input  wire logic [15:0]     ORB_DATA_SIZE_IN,
  input  wire logic            TX_ORB_LOAD_IN,
  input  wire logic            RX_ORB_LOAD_IN,
  input  wire logic            TX_PAGE_FETCH_IN,
  input  wire logic            RX_PAGE_FETCH_IN,
  output logic [15:0]          TX_PAGES_LEFT_OUT,
  output logic [15:0]          RX_PAGES_LEFT_OUT,
  // request packet as sent by the packetizer
  input  wire logic            REQ_HDR_LOAD_IN,
  input  wire logic [1:0]      REQ_SPEED_IN,
  input  wire logic [5:0]      REQ_LABEL_IN,
  input  wire logic [1:0]      REQ_RETRY_IN,
  input  wire logic [3:0]      REQ_TYPE_IN,
  input  wire logic [3:0]      REQ_PRIO_IN,
  input  wire logic            PKTZ_STATUS_LOAD_IN,
  input  wire trh_pkt_status_t PKTZ_STATUS_IN,
  // programmed header toward the packetizer
  output logic                 PACKETIZER_ENABLE_OUT,
  output logic [1:0]           HEADER_VIEW_SELECT_OUT,
  output logic [15:0]          REQ_TARGET_NODE_OUT,
  output logic [15:0]          REQ_TARGET_OFFSET_UPPER_OUT,
  output logic [31:0]          REQ_TARGET_OFFSET_LOWER_OUT,
  output logic [15:0]          REQ_LENGTH_OUT,
  output logic [15:0]          REQ_EXT_TYPE_CODE_OUT,
  output logic [3:0]           REQ_TYPE_CODE_OUT
);
  // ***************************************
  // state
  // ***************************************
  logic [1:0]  header_view_select;
  logic        auto_packetizer_enable;
  logic [1:0]  request_speed_code;
  logic [5:0]  request_label;
  logic [1:0]  request_retry_code;
  logic [3:0]  request_type_code;
  logic [3:0]  request_priority;
  trh_word_t   hdr1;
  trh_word_t   hdr2;
  trh_word_t   hdr3;
  trh_word_t   hdr0_word;
  trh_word_t   pages_word;
  trh_word_t   next_rdata;
  trh_quads_t  status_quads;
  logic        setup;
  logic        wr_acc;
  logic        mapped;
  logic        hdr_open;
  logic        stat_view;
  trh_word_t   next_ctrl;
  trh_word_t   next_pages;
  trh_word_t   next_hdr1;
  trh_word_t   next_hdr2;
  trh_word_t   next_hdr3;

  // ***************************************
  // helpers
  // ***************************************
  // byte lane merge used by every writable register
  function automatic trh_word_t merge_bytes(input trh_word_t old_w,
                                            input trh_word_t new_w,
                                            input logic [3:0] strb);
    trh_word_t res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ***************************************
  // apb decode
  // ***************************************
  // zero wait states: every access phase completes at once
  assign PREADY_OUT = 1'b1;
  assign setup      = PSEL_IN && !PENABLE_IN;
  assign wr_acc     = PSEL_IN && PENABLE_IN && PWRITE_IN;
  // anything but 01 shows the request header
  assign stat_view  = (header_view_select == `TRH_VIEW_STAT);
  // target fields lock while the packetizer owns the header
  assign hdr_open   = !auto_packetizer_enable && !stat_view;

  // legal offsets are word aligned members of the map
  always_comb begin
    case (PADDR_IN)
      `TRH_OFF_CTRL,
      `TRH_OFF_PAGES,
      `TRH_OFF_HDR0,
      `TRH_OFF_HDR1,
      `TRH_OFF_HDR2,
      `TRH_OFF_HDR3: mapped = 1'b1;
      default:       mapped = 1'b0;
    endcase
  end

  // merged write values for each writable register
  assign next_ctrl  = merge_bytes({29'h0, auto_packetizer_enable, header_view_select},
                                  PWDATA_IN, PSTRB_IN);
  assign next_pages = merge_bytes(pages_word, PWDATA_IN, PSTRB_IN);
  assign next_hdr1  = merge_bytes(hdr1, PWDATA_IN, PSTRB_IN);
  assign next_hdr2  = merge_bytes(hdr2, PWDATA_IN, PSTRB_IN);
  assign next_hdr3  = merge_bytes(hdr3, PWDATA_IN, PSTRB_IN);

  // ***************************************
  // control register
  // ***************************************
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      header_view_select     <= `TRH_VIEW_REQ;
      auto_packetizer_enable <= 1'b0;
    end else if (wr_acc && PADDR_IN == `TRH_OFF_CTRL) begin
      header_view_select     <= next_ctrl[`TRH_VIEW_LSB +: 2];
      auto_packetizer_enable <= next_ctrl[`TRH_PKTZ_BIT];
    end
  end

  // ***************************************
  // page entry counters
  // ***************************************
  trh_cnt_if tx_cnt ();
  trh_cnt_if rx_cnt ();

  // orb size goes to the direction whose fetch was started
  assign tx_cnt.load       = TX_ORB_LOAD_IN;
  assign tx_cnt.load_value = ORB_DATA_SIZE_IN;
  assign tx_cnt.sw_write   = wr_acc && PADDR_IN == `TRH_OFF_PAGES && (|PSTRB_IN[3:2]);
  assign tx_cnt.sw_value   = next_pages[`TRH_TX_LSB +: 16];
  assign tx_cnt.fetch_done = TX_PAGE_FETCH_IN;
  assign rx_cnt.load       = RX_ORB_LOAD_IN;
  assign rx_cnt.load_value = ORB_DATA_SIZE_IN;
  assign rx_cnt.sw_write   = wr_acc && PADDR_IN == `TRH_OFF_PAGES && (|PSTRB_IN[1:0]);
  assign rx_cnt.sw_value   = next_pages[`TRH_RX_LSB +: 16];
  assign rx_cnt.fetch_done = RX_PAGE_FETCH_IN;

  trh_page_counter u_tx_count (
    .clk_in   (CLK_IN),
    .reset_in (RESET_IN),
    .cif      (tx_cnt.counter)
  );

  trh_page_counter u_rx_count (
    .clk_in   (CLK_IN),
    .reset_in (RESET_IN),
    .cif      (rx_cnt.counter)
  );

  // msb-first numbering puts the transmit count in the upper half
  always_comb begin
    pages_word = `TRH_WORD_RST;
    pages_word[`TRH_TX_LSB +: 16] = tx_cnt.count;
    pages_word[`TRH_RX_LSB +: 16] = rx_cnt.count;
  end
  assign TX_PAGES_LEFT_OUT = tx_cnt.count;
  assign RX_PAGES_LEFT_OUT = rx_cnt.count;

  // ***************************************
  // reported request fields, quadlet 0
  // ***************************************
  // software cannot write these; only the sent packet updates them
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      request_speed_code <= `TRH_SPEED_RST;
      request_label      <= 6'h00;
      request_retry_code <= 2'h0;
      request_priority   <= 4'h0;
    end else if (REQ_HDR_LOAD_IN) begin
      request_speed_code <= REQ_SPEED_IN;
      request_label      <= REQ_LABEL_IN;
      request_retry_code <= REQ_RETRY_IN;
      request_priority   <= REQ_PRIO_IN;
    end
  end

  // packetizer enable overrides any captured type code
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      request_type_code <= `TRH_TCODE_RST;
    end else if (auto_packetizer_enable) begin
      request_type_code <= `TRH_TCODE_PKTZ;
    end else if (REQ_HDR_LOAD_IN) begin
      request_type_code <= REQ_TYPE_IN;
    end
  end

  // field placement follows msb-first bit numbering
  always_comb begin
    hdr0_word = `TRH_WORD_RST;
    hdr0_word[`TRH_SPEED_LSB +: 2] = request_speed_code;
    hdr0_word[`TRH_LABEL_LSB +: 6] = request_label;
    hdr0_word[`TRH_RETRY_LSB +: 2] = request_retry_code;
    hdr0_word[`TRH_TCODE_LSB +: 4] = request_type_code;
    hdr0_word[`TRH_PRIO_LSB +: 4]  = request_priority;
  end

  // ***************************************
  // programmed target fields, quadlets 1 to 3
  // ***************************************
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      hdr1 <= `TRH_WORD_RST;
    end else if (wr_acc && hdr_open && PADDR_IN == `TRH_OFF_HDR1) begin
      hdr1 <= next_hdr1;
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      hdr2 <= `TRH_WORD_RST;
    end else if (wr_acc && hdr_open && PADDR_IN == `TRH_OFF_HDR2) begin
      hdr2 <= next_hdr2;
    end
  end

  // length sits in the upper half, extended code in the lower
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      hdr3 <= `TRH_HDR3_RST;
    end else if (wr_acc && hdr_open && PADDR_IN == `TRH_OFF_HDR3) begin
      hdr3 <= next_hdr3;
    end
  end

  assign REQ_TARGET_NODE_OUT         = hdr1[31:16];
  assign REQ_TARGET_OFFSET_UPPER_OUT = hdr1[15:0];
  assign REQ_TARGET_OFFSET_LOWER_OUT = hdr2;
  assign REQ_LENGTH_OUT              = hdr3[31:16];
  assign REQ_EXT_TYPE_CODE_OUT       = hdr3[15:0];
  assign REQ_TYPE_CODE_OUT           = request_type_code;
  assign PACKETIZER_ENABLE_OUT       = auto_packetizer_enable;
  assign HEADER_VIEW_SELECT_OUT      = header_view_select;

  // ***************************************
  // packetizer status view
  // ***************************************
  trh_status_view u_status (
    .clk_in    (CLK_IN),
    .reset_in  (RESET_IN),
    .load_in   (PKTZ_STATUS_LOAD_IN),
    .status_in (PKTZ_STATUS_IN),
    .quads_out (status_quads)
  );

  // ***************************************
  // read path
  // ***************************************
  // the shared offsets answer from whichever view is selected
  always_comb begin
    case (PADDR_IN)
      `TRH_OFF_CTRL:  next_rdata = {29'h0, auto_packetizer_enable, header_view_select};
      `TRH_OFF_PAGES: next_rdata = pages_word;
      `TRH_OFF_HDR0:  next_rdata = stat_view ? status_quads[0] : hdr0_word;
      `TRH_OFF_HDR1:  next_rdata = stat_view ? status_quads[1] : hdr1;
      `TRH_OFF_HDR2:  next_rdata = stat_view ? status_quads[2] : hdr2;
      `TRH_OFF_HDR3:  next_rdata = stat_view ? status_quads[3] : hdr3;
      default:        next_rdata = `TRH_WORD_RST;
    endcase
  end

  // snapshot at setup so the access phase sees flip-flop data
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      PRDATA_OUT  <= `TRH_WORD_RST;
      PSLVERR_OUT <= 1'b0;
    end else if (setup) begin
      PRDATA_OUT  <= PWRITE_IN ? `TRH_WORD_RST : next_rdata;
      PSLVERR_OUT <= !mapped;
    end
  end

  // ***************************************
  // checks
  // ***************************************
  reset_vals_a: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    $past(RESET_IN) |-> (hdr0_word == `TRH_HDR0_RST) && (hdr3 == `TRH_HDR3_RST)
      && (pages_word == `TRH_WORD_RST) && (status_quads == '0))
    else $error("reset values wrong");
  tcode_force_a: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    auto_packetizer_enable |=> (request_type_code == `TRH_TCODE_PKTZ))
    else $error("type code not forced while packetizing");
  locked_write_a: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (wr_acc && auto_packetizer_enable && PADDR_IN == `TRH_OFF_HDR1)
      |=> $stable(hdr1))
    else $error("target node changed while locked");
  open_write_a: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (wr_acc && hdr_open && PADDR_IN == `TRH_OFF_HDR2 && PSTRB_IN == 4'hF)
      |=> (REQ_TARGET_OFFSET_LOWER_OUT == $past(PWDATA_IN)))
    else $error("open header write not stored");
  view_read_a: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (setup && !PWRITE_IN && PADDR_IN == `TRH_OFF_HDR1)
      |=> (PRDATA_OUT == ($past(stat_view) ? $past(status_quads[1]) : $past(hdr1))))
    else $error("wrong view on shared offset");
  hdr0_ro_a: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (wr_acc && PADDR_IN == `TRH_OFF_HDR0 && !REQ_HDR_LOAD_IN)
      |=> (request_label == $past(request_label))
      && (request_priority == $past(request_priority)))
    else $error("read-only header field written");
  capture_a: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    REQ_HDR_LOAD_IN |=> (request_retry_code == $past(REQ_RETRY_IN))
      && (request_speed_code == $past(REQ_SPEED_IN)))
    else $error("sent request fields not captured");
  unmapped_err_a: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (setup && !mapped) |=> PSLVERR_OUT && (PRDATA_OUT == `TRH_WORD_RST))
    else $error("unmapped access not flagged");
  locked_tail_a: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (wr_acc && !hdr_open && PADDR_IN == `TRH_OFF_HDR3)
      |=> $stable(hdr3))
    else $error("quadlet 3 changed while locked");
  speed_ro_a: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    !REQ_HDR_LOAD_IN |=> $stable(request_speed_code))
    else $error("speed code changed without a sent request");
  err_clear_a: assert property (
    @(posedge CLK_IN) disable iff (RESET_IN)
    (setup && mapped) |=> !PSLVERR_OUT)
    else $error("mapped access flagged as error");
endmodule

// ==== src/trh_dummy_unused.sv ====
// spare source file; it holds no logic of the block

// ==== test/trh_far_model.sv ====
// far-side model: page fetch engine and packetizer feeding the block
`timescale 1ns/1ps
module trh_far_model
  import trh_pkg::*;
(
  input  wire logic       clk_in,
  output logic [15:0]     orb_size_out,
  output logic [5:0]      pulse_out,
  output logic [17:0]     hdr_out,
  output trh_pkt_status_t status_out
);
  // ***************************************
  // stimulus toward the block
  // ***************************************
  // quiet until a scenario asks for traffic
  initial begin
    orb_size_out = 16'h0000;
    pulse_out    = 6'h00;
    hdr_out      = 18'h00000;
    status_out   = '0;
  end
  // data first, so it is settled before any strobe samples it
  task automatic set(input logic [15:0] sz, input logic [17:0] h, input trh_pkt_status_t s);
    @(posedge clk_in);
    orb_size_out <= sz;
    hdr_out      <= h;
    status_out   <= s;
  endtask
  // one-cycle strobe: orb tx, orb rx, fetch tx, fetch rx, header, status
  task automatic pulse(input int k);
    @(posedge clk_in);
    pulse_out <= 6'h01 << k;
    @(posedge clk_in);
    pulse_out <= 6'h00;
    @(negedge clk_in);
  endtask
endmodule

// ==== test/trh_top_tb_top.sv ====
// self-checking bench for the request header and page count block
`timescale 1ns/1ps
module trh_top_tb_top
  import trh_pkg::*;
();
  logic            clk = 1'b0;
  logic            rst;
  logic            psel;
  logic            pen;
  logic            pwr;
  logic [7:0]      paddr;
  logic [31:0]     pwdata;
  logic [3:0]      pstrb;
  logic [3:0]      lanes = 4'hF;
  logic [31:0]     prdata, offl, rv;
  logic            pready, pslverr, pk, re;
  logic [1:0]      vs;
  logic [3:0]      tco;
  logic [15:0]     orb, txl, rxl, node, offu, len, ext;
  logic [5:0]      pul;
  logic [17:0]     hdr;
  trh_pkt_status_t st;
  int              n_errors = 0;
  int              cmp_count = 0;

  // 50 ns clock
  always #25 clk = ~clk;

  trh_top dut (
    .CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .ORB_DATA_SIZE_IN(orb), .TX_ORB_LOAD_IN(pul[0]), .RX_ORB_LOAD_IN(pul[1]),
    .TX_PAGE_FETCH_IN(pul[2]), .RX_PAGE_FETCH_IN(pul[3]),
    .TX_PAGES_LEFT_OUT(txl), .RX_PAGES_LEFT_OUT(rxl), .REQ_HDR_LOAD_IN(pul[4]),
    .REQ_SPEED_IN(hdr[17:16]), .REQ_LABEL_IN(hdr[15:10]), .REQ_RETRY_IN(hdr[9:8]),
    .REQ_TYPE_IN(hdr[7:4]), .REQ_PRIO_IN(hdr[3:0]), .PKTZ_STATUS_LOAD_IN(pul[5]),
    .PKTZ_STATUS_IN(st), .PACKETIZER_ENABLE_OUT(pk), .HEADER_VIEW_SELECT_OUT(vs),
    .REQ_TARGET_NODE_OUT(node), .REQ_TARGET_OFFSET_UPPER_OUT(offu),
    .REQ_TARGET_OFFSET_LOWER_OUT(offl), .REQ_LENGTH_OUT(len),
    .REQ_EXT_TYPE_CODE_OUT(ext), .REQ_TYPE_CODE_OUT(tco));

  trh_far_model far (.clk_in(clk), .orb_size_out(orb), .pulse_out(pul),
    .hdr_out(hdr), .status_out(st));

  // ***************************************
  // bus tasks and checks
  // ***************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // setup, then access held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= lanes;
    @(posedge clk);
    pen <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(rv, x);
  endtask
  task automatic t_reset();
    rd(8'hE4, 32'h0000_0000);
    rd(8'hE8, 32'h0001_0010);
    rd(8'hF4, 32'h0008_0000);
    chk(32'(tco), 32'h1);
  endtask
  task automatic t_counts();
    apb(1'b1, 8'hE4, 32'h0003_0005);
    chk(32'(txl), 32'h3);
    chk(32'(rxl), 32'h5);
    repeat (4) far.pulse(2);
    chk(32'(txl), 32'h0);
    far.pulse(3);
    chk(32'(rxl), 32'h4);
    far.set(16'h0010, 18'h00000, '0);
    far.pulse(0);
    rd(8'hE4, 32'h0010_0004);
    // low lanes only: the transmit half must keep its count
    lanes = 4'h3;
    apb(1'b1, 8'hE4, 32'hFFFF_0002);
    lanes = 4'hF;
    rd(8'hE4, 32'h0010_0002);
  endtask
  task automatic t_target();
    apb(1'b1, 8'hEC, 32'h1111_2222);
    apb(1'b1, 8'hF0, 32'h3333_4444);
    apb(1'b1, 8'hF4, 32'h0020_0005);
    chk(32'(node), 32'h1111);
    chk(32'(offu), 32'h2222);
    chk(offl, 32'h3333_4444);
    chk(32'(ext), 32'h5);
    chk(32'(len), 32'h20);
    apb(1'b1, 8'h90, 32'h0000_0004);
    chk(32'(pk), 32'h1);
    apb(1'b1, 8'hEC, 32'hFFFF_FFFF);
    apb(1'b1, 8'hF4, 32'hFFFF_FFFF);
    rd(8'hEC, 32'h1111_2222);
    rd(8'hF4, 32'h0020_0005);
    apb(1'b1, 8'h90, 32'h0000_0000);
  endtask
  task automatic t_capture();
    far.set(16'h0000, {2'h2, 6'h2B, 2'h3, 4'hA, 4'h5}, '0);
    far.pulse(4);
    rd(8'hE8, 32'h0002_AFA5);
    apb(1'b1, 8'hE8, 32'hFFFF_FFFF);
    rd(8'hE8, 32'h0002_AFA5);
    apb(1'b1, 8'h90, 32'h0000_0004);
    far.pulse(4);
    rd(8'hE8, 32'h0002_AF15);
    apb(1'b1, 8'h90, 32'h0000_0000);
  endtask
  task automatic t_status();
    apb(1'b1, 8'h90, 32'h0000_0001);
    chk(32'(vs), 32'h1);
    rd(8'hE8, 32'h0000_0000);
    far.set(16'h0000, 18'h00000, {4'hC, 4'h3, 1'b1, 4'h6, 4'h2, 4'h9, 1'b1,
      32'h1234_5678, 16'hABCD, 16'h0102, 32'hDEAD_BEEF});
    far.pulse(5);
    rd(8'hE8, 32'hC316_2910);
    rd(8'hEC, 32'h1234_5678);
    rd(8'hF0, 32'hABCD_0102);
    rd(8'hF4, 32'hDEAD_BEEF);
    apb(1'b1, 8'h90, 32'h0000_0002);
    rd(8'hEC, 32'h1111_2222);
    apb(1'b1, 8'h90, 32'h0000_0000);
  endtask
  // unmapped and unaligned places answer with an error
  task automatic t_unmapped();
    rd(8'h80, 32'h0000_0000);
    chk(32'(re), 32'h1);
    apb(1'b1, 8'hE6, 32'hFFFF_FFFF);
    chk(32'(re), 32'h1);
    rd(8'hE4, 32'h0010_0002);
    chk(32'(re), 32'h0);
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // main sequence after 12 cycles of reset
  initial begin
    rst    <= 1'b1;
    psel   <= 1'b0;
    pen    <= 1'b0;
    pwr    <= 1'b0;
    paddr  <= 8'h00;
    pwdata <= 32'h0000_0000;
    pstrb  <= 4'hF;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_counts();
    t_target();
    t_capture();
    t_status();
    t_unmapped();
    summarize();
  end
  // whole run is about 135 cycles; this cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule
